// >>> common/atsb_pkg.sv
package atsb_pkg;
  localparam logic [2:0] ATSB_ADDR_STATUS = 3'h0;
  localparam logic [2:0] ATSB_ADDR_COUNTER = 3'h1;
  localparam logic [2:0] ATSB_ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ATSB_ADDR_CONTROL = 3'h3;
  localparam logic [2:0] ATSB_ADDR_PRESCALE = 3'h4;
  localparam int ATSB_AS_BIT = 3;
  localparam int ATSB_CNT_UB_BIT = 2;
  localparam int ATSB_CMP_UB_BIT = 1;
  localparam int ATSB_CTL_UB_BIT = 0;
  localparam int ATSB_CTL_FORCE_BIT = 7;
  localparam int ATSB_CTL_WGM0_BIT = 6;
  localparam int ATSB_CTL_COM_LSB = 4;
  localparam int ATSB_CTL_WGM1_BIT = 3;
  localparam int ATSB_CTL_CS_LSB = 0;
  localparam int ATSB_PSR_BIT = 0;
  localparam logic [7:0] ATSB_STATUS_RST = 8'h00;
  localparam logic [7:0] ATSB_COUNTER_RST = 8'h00;
  localparam logic [7:0] ATSB_COMPARE_RST = 8'h00;
  localparam logic [7:0] ATSB_CONTROL_RST = 8'h00;
  localparam logic [7:0] ATSB_TOP_VALUE = 8'hFF;
  localparam int ATSB_XFER_EDGES = 2;
  localparam int ATSB_FLAG_SYNC_CYCLES = 3;
  localparam int ATSB_WAKE_STALL_CYCLES = 4;
  localparam int ATSB_PRE_W = 10;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } atsb_bus_s;

  typedef enum logic [2:0] {
    ATSB_SLEEP_NONE = 3'h0,
    ATSB_SLEEP_IDLE = 3'h1,
    ATSB_SLEEP_SAVE = 3'h2,
    ATSB_SLEEP_EXT_STBY = 3'h3,
    ATSB_SLEEP_DOWN = 3'h4,
    ATSB_SLEEP_STBY = 3'h5
  } atsb_sleep_e;

  typedef enum logic [1:0] {
    ATSB_W_IDLE = 2'b00,
    ATSB_W_PEND = 2'b01,
    ATSB_W_STALL = 2'b11,
    ATSB_W_RECOVER = 2'b10
  } atsb_wake_e;

  function automatic logic [ATSB_PRE_W-1:0] atsb_pre_mask(input logic [2:0] cs);
    case (cs)
      3'h2: atsb_pre_mask = 10'h007;
      3'h3: atsb_pre_mask = 10'h01F;
      3'h4: atsb_pre_mask = 10'h03F;
      3'h5: atsb_pre_mask = 10'h07F;
      3'h6: atsb_pre_mask = 10'h0FF;
      3'h7: atsb_pre_mask = 10'h3FF;
      default: atsb_pre_mask = 10'h000;
    endcase
  endfunction
endpackage

// >>> src/atsb_sync_reg.sv
module atsb_sync_reg
  import atsb_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_async,
  input wire logic i_osc_rise,
  output logic o_busy,
  output logic [W-1:0] o_temp,
  output logic o_load
);
  logic [1:0] edges;

  // Temporary register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_temp <= RST_VAL;
    end else if (i_wr) begin
      o_temp <= i_wdata;
    end
  end

  // Busy flag, edge count and load pulse
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      edges <= 2'h0;
      o_load <= 1'b0;
    end else begin
      o_load <= 1'b0;
      if (i_wr) begin
        edges <= 2'h0;
        o_busy <= i_async;
        o_load <= !i_async;
      end else if (o_busy && i_osc_rise) begin
        if (edges == 2'(ATSB_XFER_EDGES - 1)) begin
          o_busy <= 1'b0;
          o_load <= 1'b1;
        end else begin
          edges <= edges + 2'h1;
        end
      end
    end
  end

  AST_WR_SETS_BUSY: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_wr && i_async |=> o_busy && !o_load) else $error("busy not set by async write");
  AST_SYNC_LOADS_NOW: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_wr && !i_async |=> !o_busy && o_load) else $error("sync write not loaded");
endmodule

// >>> src/atsb_top.sv
// Notes on behaviour
// - Select bit picks I/O clock or crystal
// - Switching source leaves timer registers unknown
// - Counter write sets counter busy flag
// - Compare write sets compare busy flag
// - Control write sets control busy flag
// - Counter reads live count in sync mode, compare and control read temporaries
// - Writes land after two crystal edges
// - Counter, compare and control each have own temporary
// - Pending counter/compare write blocks match
// - One crystal cycle before rearming wake
// - Crystal runs except power-down, standby
// - Wake starts on next timer tick
// - Processor stalls four cycles after wake
// - Counter read resynced on crystal edge
// - Flags arrive three cycles after tick
// - Compare pin driven in timer domain
// - Prescaler reset bit held until done
module atsb_top
  import atsb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire atsb_bus_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_timer_osc_in,
  input wire atsb_sleep_e i_sleep_mode,
  input wire logic i_compare_irq_enable,
  input wire logic i_overflow_irq_enable,
  output logic o_async_clock_select,
  output logic o_osc_run,
  output logic o_compare_pin,
  output logic o_compare_flag_set,
  output logic o_overflow_flag_set,
  output logic o_wake,
  output logic o_cpu_stall
);
  localparam int FLAG_DLY = ATSB_FLAG_SYNC_CYCLES;

  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic osc_rise;
  logic src_tick;
  logic cnt_en;
  logic [7:0] counter;
  logic [7:0] cnt_read;
  logic [7:0] compare_value;
  logic [7:0] timer_control;
  logic prescaler_reset_bit;
  logic [ATSB_PRE_W-1:0] pre;
  logic cnt_busy;
  logic cmp_busy;
  logic ctl_busy;
  logic cnt_load;
  logic cmp_load;
  logic ctl_load;
  logic [7:0] cnt_temp;
  logic [7:0] cmp_temp;
  logic [7:0] ctl_temp;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_ctl;
  logic match;
  logic match_evt;
  logic ovf_evt;
  logic [FLAG_DLY-1:0] cmp_pipe;
  logic [FLAG_DLY-1:0] ovf_pipe;
  logic cmp_hold;
  logic ovf_hold;
  logic cmp_in;
  logic ovf_in;
  logic [2:0] stall_cnt;
  logic wake_sleep;
  logic wake_cond;
  atsb_wake_e wake_state;
  atsb_wake_e next_wake_state;

  assign wr_cnt = i_bus.wr && (i_bus.addr == ATSB_ADDR_COUNTER);
  assign wr_cmp = i_bus.wr && (i_bus.addr == ATSB_ADDR_COMPARE);
  assign wr_ctl = i_bus.wr && (i_bus.addr == ATSB_ADDR_CONTROL);

  // Crystal input synchroniser and edge detect
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= i_timer_osc_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end
  assign osc_rise = osc_s2 && !osc_s3;

  // Clock source select
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_async_clock_select <= ATSB_STATUS_RST[ATSB_AS_BIT];
    end else if (i_bus.wr && i_bus.addr == ATSB_ADDR_STATUS) begin
      o_async_clock_select <= i_bus.wdata[ATSB_AS_BIT];
    end
  end
  assign src_tick = o_async_clock_select ? osc_rise : 1'b1;
  assign o_osc_run = o_async_clock_select
    && !(i_sleep_mode == ATSB_SLEEP_DOWN || i_sleep_mode == ATSB_SLEEP_STBY);

  // Per-register temporaries
  atsb_sync_reg #(.W(8), .RST_VAL(ATSB_COUNTER_RST)) u_cnt_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_cnt),
    .i_wdata(i_bus.wdata),
    .i_async(o_async_clock_select),
    .i_osc_rise(osc_rise),
    .o_busy(cnt_busy),
    .o_temp(cnt_temp),
    .o_load(cnt_load)
  );
  atsb_sync_reg #(.W(8), .RST_VAL(ATSB_COMPARE_RST)) u_cmp_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_cmp),
    .i_wdata(i_bus.wdata),
    .i_async(o_async_clock_select),
    .i_osc_rise(osc_rise),
    .o_busy(cmp_busy),
    .o_temp(cmp_temp),
    .o_load(cmp_load)
  );
  atsb_sync_reg #(.W(8), .RST_VAL(ATSB_CONTROL_RST)) u_ctl_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_ctl),
    .i_wdata(i_bus.wdata),
    .i_async(o_async_clock_select),
    .i_osc_rise(osc_rise),
    .o_busy(ctl_busy),
    .o_temp(ctl_temp),
    .o_load(ctl_load)
  );

  // Destination registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      compare_value <= ATSB_COMPARE_RST;
      timer_control <= ATSB_CONTROL_RST;
    end else begin
      if (cmp_load) begin
        compare_value <= cmp_temp;
      end
      if (ctl_load) begin
        timer_control <= ctl_temp;
      end
    end
  end

  // Prescaler reset bit
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      prescaler_reset_bit <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == ATSB_ADDR_PRESCALE && i_bus.wdata[ATSB_PSR_BIT]) begin
      prescaler_reset_bit <= 1'b1;
    end else if (prescaler_reset_bit && src_tick) begin
      prescaler_reset_bit <= 1'b0;
    end
  end

  // Prescaler
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pre <= '0;
    end else if (prescaler_reset_bit && src_tick) begin
      pre <= '0;
    end else if (src_tick) begin
      pre <= pre + 1'b1;
    end
  end
  assign cnt_en = src_tick && !prescaler_reset_bit
    && (timer_control[ATSB_CTL_CS_LSB +: 3] != 3'h0)
    && ((pre & atsb_pre_mask(timer_control[ATSB_CTL_CS_LSB +: 3]))
        == atsb_pre_mask(timer_control[ATSB_CTL_CS_LSB +: 3]));

  // Compare match, blocked while a counter or compare write is pending
  assign match = (counter == compare_value) && !cnt_busy && !cmp_busy;
  assign match_evt = cnt_en && match;
  assign ovf_evt = cnt_en && (counter == ATSB_TOP_VALUE);

  // Counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      counter <= ATSB_COUNTER_RST;
    end else if (cnt_load) begin
      counter <= cnt_temp;
    end else if (cnt_en) begin
      if (match && timer_control[ATSB_CTL_WGM1_BIT] && !timer_control[ATSB_CTL_WGM0_BIT]) begin
        counter <= 8'h00;
      end else begin
        counter <= counter + 8'h01;
      end
    end
  end

  // Read copy of the count
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cnt_read <= ATSB_COUNTER_RST;
    end else if (!o_async_clock_select || osc_rise) begin
      cnt_read <= counter;
    end
  end

  // Compare pin in timer domain
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_compare_pin <= 1'b0;
    end else if (match_evt) begin
      case (timer_control[ATSB_CTL_COM_LSB +: 2])
        2'h1: o_compare_pin <= !o_compare_pin;
        2'h2: o_compare_pin <= 1'b0;
        2'h3: o_compare_pin <= 1'b1;
        default: o_compare_pin <= o_compare_pin;
      endcase
    end
  end

  // Events wait for the next crystal tick
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst || !o_async_clock_select) begin
      cmp_hold <= 1'b0;
      ovf_hold <= 1'b0;
    end else begin
      cmp_hold <= match_evt || (cmp_hold && !osc_rise);
      ovf_hold <= ovf_evt || (ovf_hold && !osc_rise);
    end
  end
  assign cmp_in = o_async_clock_select ? (cmp_hold && osc_rise) : match_evt;
  assign ovf_in = o_async_clock_select ? (ovf_hold && osc_rise) : ovf_evt;

  // Flag transport to processor domain
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cmp_pipe <= '0;
      ovf_pipe <= '0;
      o_compare_flag_set <= 1'b0;
      o_overflow_flag_set <= 1'b0;
    end else begin
      cmp_pipe <= {cmp_pipe[FLAG_DLY-2:0], cmp_in};
      ovf_pipe <= {ovf_pipe[FLAG_DLY-2:0], ovf_in};
      o_compare_flag_set <= cmp_pipe[FLAG_DLY-2];
      o_overflow_flag_set <= ovf_pipe[FLAG_DLY-2];
    end
  end

  // Wake sequencing
  assign wake_sleep = o_async_clock_select
    && (i_sleep_mode == ATSB_SLEEP_SAVE || i_sleep_mode == ATSB_SLEEP_EXT_STBY);
  assign wake_cond = (match_evt && i_compare_irq_enable) || (ovf_evt && i_overflow_irq_enable);

  always_comb begin
    next_wake_state = wake_state;
    case (wake_state)
      ATSB_W_IDLE: begin
        if (wake_sleep && wake_cond) begin
          next_wake_state = ATSB_W_PEND;
        end
      end
      ATSB_W_PEND: begin
        if (src_tick) begin
          next_wake_state = ATSB_W_STALL;
        end
      end
      ATSB_W_STALL: begin
        if (stall_cnt == 3'(ATSB_WAKE_STALL_CYCLES - 1)) begin
          next_wake_state = ATSB_W_RECOVER;
        end
      end
      ATSB_W_RECOVER: begin
        if (src_tick) begin
          next_wake_state = ATSB_W_IDLE;
        end
      end
      default: next_wake_state = ATSB_W_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wake_state <= ATSB_W_IDLE;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      stall_cnt <= 3'h0;
    end else if (wake_state == ATSB_W_STALL) begin
      stall_cnt <= stall_cnt + 3'h1;
    end else begin
      stall_cnt <= 3'h0;
    end
  end

  assign o_wake = (wake_state == ATSB_W_PEND) && src_tick;
  assign o_cpu_stall = (wake_state == ATSB_W_STALL);

  // Register read
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        ATSB_ADDR_STATUS: o_rdata <= {4'h0, o_async_clock_select, cnt_busy, cmp_busy, ctl_busy};
        ATSB_ADDR_COUNTER: o_rdata <= o_async_clock_select ? cnt_read : counter;
        ATSB_ADDR_COMPARE: o_rdata <= cmp_temp;
        ATSB_ADDR_CONTROL: o_rdata <= {1'b0, ctl_temp[ATSB_CTL_FORCE_BIT-1:0]};
        ATSB_ADDR_PRESCALE: o_rdata <= {7'h00, prescaler_reset_bit};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  AST_FLAG_DELAY: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    cmp_in |-> ##FLAG_DLY o_compare_flag_set) else $error("compare flag delay wrong");
  AST_FLAG_TICK: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_async_clock_select && match_evt |=> cmp_hold) else $error("flag not held for a tick");
  AST_STALL_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(o_cpu_stall) |-> o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("stall not four cycles");
  AST_MATCH_BLOCK: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (cnt_busy || cmp_busy) |-> !match_evt) else $error("match while write pending");
  AST_OSC_STOP: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sleep_mode == ATSB_SLEEP_DOWN) |-> !o_osc_run) else $error("oscillator running in power-down");
  AST_RD_TEMP: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_bus.rd && i_bus.addr == ATSB_ADDR_COMPARE |=> o_rdata == $past(cmp_temp))
    else $error("compare read not temporary");
  AST_PSR_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_async_clock_select && prescaler_reset_bit && !osc_rise |=> prescaler_reset_bit)
    else $error("prescaler reset released early");
  AST_WAKE_TICK: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    wake_state == ATSB_W_IDLE && wake_sleep && wake_cond |=> !o_cpu_stall && !o_wake)
    else $error("wake started in same tick");
  AST_CNT_READ_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_async_clock_select && !osc_rise |=> $stable(cnt_read)) else $error("count copy moved off edge");
  AST_BUSY_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $fell(cmp_busy) |-> ##1 compare_value == cmp_temp) else $error("compare not loaded at busy clear");

  COV_ASYNC_XFER: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $fell(cnt_busy));
  COV_WAKE: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $rose(o_cpu_stall));
  COV_OVF: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) o_overflow_flag_set);
endmodule

// >>> testbench/atsb_xtal_model.sv
module atsb_xtal_model #(
  parameter int HALF = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_run,
  output logic o_osc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    o_osc = 1'b0;
    cnt = 0;
  end
  // Crystal stands still low while stopped
  always @(negedge i_ref_clk) begin
    if (i_run !== 1'b1) begin
      o_osc <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      o_osc <= ~o_osc;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> testbench/tb_top.sv
module tb_top
  import atsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, osc, cmp_en, ovf_en;
  atsb_bus_s bus;
  atsb_sleep_e mode;
  logic [7:0] rdata, rv, r0;
  logic async_sel, osc_run, cmp_pin, cmp_flag, ovf_flag, wake, stall, p0;
  int mismatches, n_tests, n, k;

  atsb_top atsb_top_i(.i_ref_clk(ref_clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
    .i_timer_osc_in(osc), .i_sleep_mode(mode), .i_compare_irq_enable(cmp_en),
    .i_overflow_irq_enable(ovf_en), .o_async_clock_select(async_sel), .o_osc_run(osc_run),
    .o_compare_pin(cmp_pin), .o_compare_flag_set(cmp_flag), .o_overflow_flag_set(ovf_flag),
    .o_wake(wake), .o_cpu_stall(stall));
  atsb_xtal_model atsb_xtal_model_i(.i_ref_clk(ref_clk), .i_run(osc_run), .o_osc(osc));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Polls status until masked busy bits clear
  task automatic wait_idle(input logic [7:0] m, output int cnt);
    cnt = 0;
    do begin
      rd(ATSB_ADDR_STATUS, rv);
      cnt++;
    end while ((rv & m) !== 8'h00 && cnt < 500);
    if (cnt >= 500) begin
      mismatches++;
      $display("Error %0t: busy never cleared", $time);
      results();
    end
  endtask

  task automatic wait_ev(input int w, input int lim);
    int i;
    logic s;
    i = 0;
    s = 1'b0;
    while (s !== 1'b1 && i < lim) begin
      @(posedge ref_clk);
      #1;
      case (w)
        0: s = wake;
        1: s = cmp_flag;
        2: s = ovf_flag;
        3: s = osc;
        default: s = ~osc;
      endcase
      i++;
    end
    if (s !== 1'b1) begin
      mismatches++;
      $display("Error %0t: event %0d missing", $time, w);
      results();
    end
  endtask

  task automatic t_reset();
    rd(ATSB_ADDR_STATUS, rv); chk(rv, 8'h00, "status reset");
    rd(ATSB_ADDR_COUNTER, rv); chk(rv, ATSB_COUNTER_RST, "counter reset");
    rd(ATSB_ADDR_COMPARE, rv); chk(rv, ATSB_COMPARE_RST, "compare reset");
    rd(ATSB_ADDR_CONTROL, rv); chk(rv, ATSB_CONTROL_RST, "control reset");
    chk({6'h00, async_sel, osc_run}, 8'h00, "sync select");
  endtask

  task automatic t_sync();
    wr(ATSB_ADDR_COMPARE, 8'hA5);
    rd(ATSB_ADDR_STATUS, rv); chk(rv, 8'h00, "sync no busy");
    rd(ATSB_ADDR_COMPARE, rv); chk(rv, 8'hA5, "sync compare");
    wr(ATSB_ADDR_CONTROL, 8'h81);
    rd(ATSB_ADDR_CONTROL, rv); chk(rv, 8'h01, "force bit reads 0");
    wr(3'h6, 8'hFF);
    rd(3'h6, rv); chk(rv, 8'h00, "unmapped");
  endtask

  task automatic t_switch();
    @(posedge ref_clk) begin
      cmp_en <= 1'b0;
      ovf_en <= 1'b0;
    end
    wr(ATSB_ADDR_STATUS, 8'h08);
    #1 chk({7'h00, async_sel}, 8'h01, "async select");
    rd(ATSB_ADDR_STATUS, rv); chk(rv & 8'h08, 8'h08, "select bit");
    wr(ATSB_ADDR_COUNTER, 8'h00);
    rd(ATSB_ADDR_STATUS, rv); chk(rv & 8'h04, 8'h04, "counter busy");
    wait_idle(8'h07, n);
    chk({7'h00, n > 5}, 8'h01, "two crystal edges");
    wr(ATSB_ADDR_COMPARE, 8'h40);
    wr(ATSB_ADDR_CONTROL, 8'h11);
    rd(ATSB_ADDR_STATUS, rv); chk(rv & 8'h03, 8'h03, "cmp and ctl busy");
    wait_idle(8'h07, n);
    chk(rv, 8'h08, "all busy clear");
    rd(ATSB_ADDR_COMPARE, rv); chk(rv, 8'h40, "compare temp");
    rd(ATSB_ADDR_CONTROL, rv); chk(rv, 8'h11, "control temp");
  endtask

  task automatic t_modes();
    for (k = 0; k < 6; k++) begin
      @(posedge ref_clk) mode <= atsb_sleep_e'(k[2:0]);
      @(posedge ref_clk);
      #1 chk({7'h00, osc_run}, {7'h00, k < 4}, "oscillator run");
    end
    @(posedge ref_clk) mode <= ATSB_SLEEP_NONE;
  endtask

  task automatic t_count();
    rd(ATSB_ADDR_COUNTER, r0);
    repeat (40) @(posedge ref_clk);
    rd(ATSB_ADDR_COUNTER, rv); chk({7'h00, rv !== r0}, 8'h01, "live count");
    wr(ATSB_ADDR_COUNTER, 8'hFC);
    wait_idle(8'h04, n);
    wait_ev(2, 1000);
    rd(ATSB_ADDR_COUNTER, rv); chk({7'h00, rv < 8'h10}, 8'h01, "count after overflow");
  endtask

  task automatic t_pin();
    wr(ATSB_ADDR_COUNTER, 8'h38);
    wait_idle(8'h04, n);
    p0 = cmp_pin;
    wait_ev(1, 1000);
    chk({7'h00, cmp_pin}, {7'h00, ~p0}, "compare pin toggles");
  endtask

  task automatic t_presc();
    wait_ev(4, 40);
    wait_ev(3, 40);
    wr(ATSB_ADDR_PRESCALE, 8'h01);
    rd(ATSB_ADDR_PRESCALE, rv); chk(rv & 8'h01, 8'h01, "prescaler reset held");
    repeat (40) @(posedge ref_clk);
    rd(ATSB_ADDR_PRESCALE, rv); chk(rv & 8'h01, 8'h00, "prescaler reset done");
  endtask

  task automatic t_wake();
    wr(ATSB_ADDR_COUNTER, 8'h30);
    wait_idle(8'h07, n);
    @(posedge ref_clk) begin
      mode <= ATSB_SLEEP_SAVE;
      cmp_en <= 1'b1;
    end
    wait_ev(0, 1000);
    k = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1 if (stall === 1'b1) k++;
    end
    chk(k[7:0], 8'h04, "stall cycles");
    @(posedge ref_clk) begin
      mode <= ATSB_SLEEP_NONE;
      cmp_en <= 1'b0;
    end
    wr(ATSB_ADDR_CONTROL, 8'h11);
    wait_idle(8'h01, n);
    chk(rv, 8'h08, "rearm wait");
    rd(ATSB_ADDR_COUNTER, rv); chk({7'h00, rv > 8'h40}, 8'h01, "count after busy");
  endtask

  initial begin
    mismatches = 0;
    n_tests = 0;
    nrst = 1'b0;
    bus = '0;
    mode = ATSB_SLEEP_NONE;
    cmp_en = 1'b0;
    ovf_en = 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_sync();
    t_switch();
    t_modes();
    t_count();
    t_pin();
    t_presc();
    t_wake();
    results();
  end
endmodule
